// file: common/pid_loop_map.vh
// Purpose: register indices, control bits and constants of the PID engine
// Assumes: 32-bit classic Wishbone, one aligned word per register
// Notes: byte address of a register is its index times four
`ifndef PID_LOOP_MAP_VH
`define PID_LOOP_MAP_VH
`define IDX_CTRL 5'h00
`define IDX_GAIN 5'h01
`define IDX_RESET 5'h02
`define IDX_RATE 5'h03
`define IDX_SAMPLE 5'h04
`define IDX_DLIM 5'h05
`define IDX_SP 5'h06
`define IDX_MAN 5'h07
`define IDX_BIAS 5'h08
`define IDX_DBAND 5'h09
`define IDX_LIM_HH 5'h0a
`define IDX_LIM_H 5'h0b
`define IDX_LIM_L 5'h0c
`define IDX_LIM_LL 5'h0d
`define IDX_DEV_Y 5'h0e
`define IDX_DEV_O 5'h0f
`define IDX_RATE_LIM 5'h10
`define IDX_HYST 5'h11
`define IDX_LAST_RW 5'h11
`define IDX_STATUS 5'h12
`define IDX_OUT 5'h13
`define IDX_PV 5'h14
`define CB_RUN 0
`define CB_AUTO 1
`define CB_CASCADE 2
`define CB_VELOCITY 3
`define CB_REVERSE 4
`define CB_SQRT 5
`define CB_ERR_SQ 6
`define CB_DBAND 7
`define CB_DLIM 8
`define CB_FREEZE 9
`define CB_BUMP_II 10
`define CB_ORANGE 11
`define CB_FMT_LO 12
`define CB_FMT_HI 14
`define FMT_12U 3'h0
`define FMT_12B 3'h1
`define FMT_15U 3'h2
`define FMT_15B 3'h3
`define TI_OFF 16'h270f
`define GAIN_ONE 32'h0000_0100
`define ALPHA_ONE 32'h0001_0000
`define NORM_MAX 48'sh0000_0000_ffff
`define ZERO48 48'sh0000_0000_0000
`define SAMPLE_UNIT_NS 32'h000f_4240
`define CLK_PERIOD_NS 32'h0000_0028
`endif

// file: rtl/pid_loop_calc.v
// Purpose: one PID loop engine with alarms, Wishbone register slave
// Assumes: pv_raw and cascade_sp come from logic on clk_sys
// Notes: values are normalised to 16 bits, 0x0000 = 0.0, 0xffff = 1.0
// Behaviour
// - reset_interval 9999 removes integral action
// - rate_window zero removes derivative action
// - coefficients scale by gain unless gain zero
// - velocity form outputs successive output difference
// - manual to auto loads setpoint unless cascade, bias unless velocity form
// - two bumpless transfer types selectable per loop
// - four absolute pv limit alarms
// - yellow and orange deviation alarms, both sides
// - rate of change alarm on fast pv
// - alarms set when threshold is crossed
// - manual passes operator output, alarms continue
// - automatic computes output every sample
// - cascade takes setpoint from another loop
// - reverse action flips term signs
// - optional square root of pv
// - error squared uses error times magnitude
// - deadband zeroes error near setpoint
// - squaring happens before deadband test
// - derivative gain limit filters pv
// - 12, 15 and 16 bit data formats
// - bias accumulates integral term each sample
// - output clamped to zero..one
// - freeze holds bias when output saturates
`include "pid_loop_map.vh"
`timescale 1ns/1ps
`default_nettype none
module pid_loop_calc #(
	parameter MS_CYCLES = `SAMPLE_UNIT_NS / `CLK_PERIOD_NS,
	parameter CNT_W = 16
) (
	input wire clk_sys,
	input wire rst_n,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [31:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	input wire [15:0] pv_raw,
	input wire [15:0] cascade_sp,
	output reg [15:0] ctrl_out,
	output reg out_strobe,
	output reg [8:0] alarm_vec
);
	localparam [2:0] S_IDLE = 3'h1;
	localparam [2:0] S_PREP = 3'h2;
	localparam [2:0] S_CALC = 3'h4;
	localparam integer MS_LAST_I = MS_CYCLES - 1;
	localparam [CNT_W-1:0] MS_LAST = MS_LAST_I[CNT_W-1:0];

	function [15:0] merge;
		input [15:0] old;
		input [31:0] d;
		input [3:0] s;
		merge = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	function signed [17:0] s18;
		input [15:0] v;
		s18 = $signed({2'h0, v});
	endfunction

	function signed [47:0] s48;
		input [15:0] v;
		s48 = $signed({32'h0000_0000, v});
	endfunction

	function [15:0] clamp_n;
		input signed [47:0] v;
		if (v < `ZERO48)
			clamp_n = 16'h0000;
		else if (v > `NORM_MAX)
			clamp_n = 16'hffff;
		else
			clamp_n = v[15:0];
	endfunction

	function [23:0] sat24;
		input [31:0] v;
		sat24 = (|v[31:24]) ? 24'hff_ffff : v[23:0];
	endfunction

	function [15:0] from_fmt;
		input [15:0] r;
		input [2:0] f;
		case (f)
		`FMT_12U: from_fmt = {r[11:0], 4'h0};
		`FMT_12B: from_fmt = {~r[11], r[10:0], 4'h0};
		`FMT_15U: from_fmt = {r[14:0], 1'b0};
		`FMT_15B: from_fmt = {~r[14], r[13:0], 1'b0};
		default: from_fmt = r;
		endcase
	endfunction

	function [15:0] to_fmt;
		input [15:0] n;
		input [2:0] f;
		case (f)
		`FMT_12U: to_fmt = {4'h0, n[15:4]};
		`FMT_12B: to_fmt = {{5{~n[15]}}, n[14:4]};
		`FMT_15U: to_fmt = {1'b0, n[15:1]};
		`FMT_15B: to_fmt = {{2{~n[15]}}, n[14:1]};
		default: to_fmt = n;
		endcase
	endfunction

	// 16-bit increments lose one bit so the full range fits
	function [15:0] vel_fmt;
		input signed [16:0] d;
		input [2:0] f;
		reg signed [16:0] t;
		begin
			t = (f == `FMT_12U || f == `FMT_12B) ? (d >>> 4) : (d >>> 1);
			vel_fmt = t[15:0];
		end
	endfunction

	// digit-by-digit root of x/65536, result again in 16 bits
	function [15:0] isqrt;
		input [15:0] x;
		reg [31:0] v;
		reg [31:0] rem;
		reg [31:0] trial;
		reg [15:0] root;
		integer k;
		begin
			v = {x, 16'h0000};
			rem = 32'h0000_0000;
			root = 16'h0000;
			for (k = 0; k < 16; k = k + 1)
			begin
				rem = {rem[29:0], v[31:30]};
				v = {v[29:0], 2'h0};
				trial = {14'h0000, root, 2'h1};
				if (rem >= trial)
				begin
					rem = rem - trial;
					root = {root[14:0], 1'b1};
				end
				else
					root = {root[14:0], 1'b0};
			end
			isqrt = root;
		end
	endfunction

	function hyst_hi;
		input act;
		input signed [17:0] x;
		input signed [17:0] thr;
		input [15:0] hy;
		hyst_hi = act ? (x > thr - s18(hy)) : (x > thr);
	endfunction

	reg rst_meta_reg;
	reg rst_sync_reg;
	wire rst_s_n = rst_sync_reg;

	always @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rst_meta_reg <= 1'b0;
			rst_sync_reg <= 1'b0;
		end
		else
		begin
			rst_meta_reg <= 1'b1;
			rst_sync_reg <= rst_meta_reg;
		end
	end

	reg [15:0] prm_reg [0:`IDX_LAST_RW];
	reg [15:0] bias_reg;
	reg [15:0] pv_reg;
	reg [15:0] pv_last_reg;
	reg [15:0] y_reg;
	reg [15:0] y_prev_reg;
	reg [15:0] m_prev_reg;
	reg [2:0] state_reg;
	reg [CNT_W-1:0] ms_cnt_reg;
	reg [15:0] smp_cnt_reg;
	reg primed_reg;
	reg auto_prev_reg;
	reg sp_load_reg;
	reg [15:0] rd_data;
	integer i;

	wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire adr_ok = (wb_adr_i[31:7] == 25'h000_0000);
	wire [4:0] idx = wb_adr_i[6:2];
	wire wr = req & wb_we_i & adr_ok;

	wire [15:0] ctrl = prm_reg[`IDX_CTRL];
	wire [15:0] kc = prm_reg[`IDX_GAIN];
	wire [15:0] ti = prm_reg[`IDX_RESET];
	wire [15:0] td = prm_reg[`IDX_RATE];
	wire [15:0] kd = prm_reg[`IDX_DLIM];
	wire [2:0] fmt = ctrl[`CB_FMT_HI:`CB_FMT_LO];
	wire run = ctrl[`CB_RUN];
	wire casc = ctrl[`CB_CASCADE];
	wire auto_eff = ctrl[`CB_AUTO] | casc;
	wire vel = ctrl[`CB_VELOCITY];
	wire rev = ctrl[`CB_REVERSE];
	wire [15:0] ts_e = (prm_reg[`IDX_SAMPLE] == 16'h0000) ? 16'h0001 :
		prm_reg[`IDX_SAMPLE];

	// coefficients in 8.8 fixed point; division kept combinational
	// since parameters change rarely and area is not the concern here
	wire [31:0] gain_e = (kc == 16'h0000) ? `GAIN_ONE : {16'h0000, kc};
	wire [31:0] ki_q = (ti == `TI_OFF || ti == 16'h0000) ? 32'h0000_0000 :
		(gain_e * {16'h0000, ts_e}) / {16'h0000, ti};
	wire [31:0] kr_q = (td == 16'h0000) ? 32'h0000_0000 :
		(gain_e * {16'h0000, td}) / {16'h0000, ts_e};
	wire [15:0] td_kd = (kd == 16'h0000) ? 16'h0000 : td / kd;
	wire [31:0] alpha = (ctrl[`CB_DLIM] && kd != 16'h0000) ?
		({ts_e, 16'h0000} / ({16'h0000, ts_e} + {16'h0000, td_kd})) :
		`ALPHA_ONE;

	wire [15:0] pv_n = from_fmt(pv_raw, fmt);
	wire [15:0] pv_p = ctrl[`CB_SQRT] ? isqrt(pv_n) : pv_n;
	wire signed [17:0] y_diff = s18(pv_p) - s18(y_reg);
	wire signed [35:0] y_step = $signed({1'b0, alpha[16:0]}) * y_diff;
	wire signed [17:0] y_nx = s18(y_reg) + $signed(y_step[33:16]);

	wire [15:0] sp_e = casc ? from_fmt(cascade_sp, fmt) :
		prm_reg[`IDX_SP];
	wire signed [17:0] pv_s = s18(pv_reg);
	wire signed [17:0] sp_s = s18(sp_e);
	wire signed [17:0] e_raw = sp_s - pv_s;
	wire signed [17:0] e_abs = e_raw[17] ? -e_raw : e_raw;
	wire signed [35:0] e_prod = e_raw * e_abs;
	wire signed [17:0] e_sq = ctrl[`CB_ERR_SQ] ? e_prod[33:16] : e_raw;
	wire signed [17:0] e_mag = e_sq[17] ? -e_sq : e_sq;
	wire db_in = ctrl[`CB_DBAND] && (e_mag <= s18(prm_reg[`IDX_DBAND]));
	wire signed [17:0] e_n = db_in ? 18'sh0_0000 : e_sq;
	wire signed [17:0] dy = s18(y_reg) - s18(y_prev_reg);

	wire signed [47:0] p_t = (kc == 16'h0000) ? `ZERO48 :
		($signed({1'b0, kc}) * e_n) >>> 8;
	wire signed [47:0] i_t = ($signed({1'b0, sat24(ki_q)}) * e_n) >>> 8;
	wire signed [47:0] d_t = ($signed({1'b0, sat24(kr_q)}) * dy) >>> 8;
	wire signed [47:0] p_d = rev ? -p_t : p_t;
	wire signed [47:0] i_d = rev ? -i_t : i_t;
	wire signed [47:0] d_d = rev ? -d_t : d_t;
	wire signed [47:0] mx_w = s48(bias_reg) + i_d;
	wire signed [47:0] m_w = p_d - d_d + mx_w;
	wire in_rng = (m_w >= `ZERO48) && (m_w <= `NORM_MAX);
	wire [15:0] m_cl = clamp_n(m_w);
	// adjusting the bias lets the output leave the rail at once
	wire [15:0] bias_nx = in_rng ? clamp_n(mx_w) :
		(ctrl[`CB_FREEZE] ? bias_reg :
		clamp_n(s48(m_cl) - p_d + d_d));
	wire xfer = auto_eff && !auto_prev_reg;
	wire [15:0] m_new = !auto_eff ? from_fmt(prm_reg[`IDX_MAN], fmt) :
		(xfer ? m_prev_reg : m_cl);
	wire signed [16:0] m_delta = $signed({1'b0, m_new}) -
		$signed({1'b0, m_prev_reg});

	wire signed [17:0] dev = pv_s - sp_s;
	wire signed [17:0] pv_rate = pv_s - s18(pv_last_reg);
	wire [15:0] hy = prm_reg[`IDX_HYST];
	wire [15:0] dy_lim = prm_reg[`IDX_DEV_Y];
	wire [15:0] do_lim = prm_reg[`IDX_DEV_O];
	wire orange = ctrl[`CB_ORANGE] && do_lim != 16'h0000;
	wire [8:0] alm_nx;
	// a zero limit switches that alarm off
	assign alm_nx[0] = prm_reg[`IDX_LIM_HH] != 16'h0000 &&
		hyst_hi(alarm_vec[0], pv_s, s18(prm_reg[`IDX_LIM_HH]), hy);
	assign alm_nx[1] = prm_reg[`IDX_LIM_H] != 16'h0000 &&
		hyst_hi(alarm_vec[1], pv_s, s18(prm_reg[`IDX_LIM_H]), hy);
	assign alm_nx[2] = prm_reg[`IDX_LIM_L] != 16'h0000 &&
		hyst_hi(alarm_vec[2], -pv_s, -s18(prm_reg[`IDX_LIM_L]), hy);
	assign alm_nx[3] = prm_reg[`IDX_LIM_LL] != 16'h0000 &&
		hyst_hi(alarm_vec[3], -pv_s, -s18(prm_reg[`IDX_LIM_LL]), hy);
	assign alm_nx[4] = dy_lim != 16'h0000 &&
		hyst_hi(alarm_vec[4], dev, s18(dy_lim), hy);
	assign alm_nx[5] = dy_lim != 16'h0000 &&
		hyst_hi(alarm_vec[5], -dev, s18(dy_lim), hy);
	assign alm_nx[6] = orange &&
		hyst_hi(alarm_vec[6], dev, s18(do_lim), hy);
	assign alm_nx[7] = orange &&
		hyst_hi(alarm_vec[7], -dev, s18(do_lim), hy);
	assign alm_nx[8] = prm_reg[`IDX_RATE_LIM] != 16'h0000 &&
		((pv_rate[17] ? -pv_rate : pv_rate) >
		s18(prm_reg[`IDX_RATE_LIM]));

	wire tick = (ms_cnt_reg == MS_LAST) &&
		(smp_cnt_reg >= ts_e - 16'h0001);

	always @*
	begin
		rd_data = 16'h0000;
		if (idx == `IDX_BIAS)
			rd_data = bias_reg;
		else if (idx <= `IDX_LAST_RW)
			rd_data = prm_reg[idx];
		else if (idx == `IDX_STATUS)
			rd_data = {5'h00, auto_prev_reg, state_reg != S_IDLE, alarm_vec};
		else if (idx == `IDX_OUT)
			rd_data = ctrl_out;
		else if (idx == `IDX_PV)
			rd_data = pv_reg;
	end

	// unmapped addresses are acknowledged and read as zero
	always @(posedge clk_sys or negedge rst_s_n)
	begin
		if (!rst_s_n)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_o <= req;
			if (req)
				wb_dat_o <= {16'h0000, adr_ok ? rd_data : 16'h0000};
		end
	end

	always @(posedge clk_sys or negedge rst_s_n)
	begin
		if (!rst_s_n)
		begin
			for (i = 0; i <= `IDX_LAST_RW; i = i + 1)
				prm_reg[i] <= 16'h0000;
		end
		else
		begin
			if (wr && idx <= `IDX_LAST_RW && idx != `IDX_BIAS)
				prm_reg[idx] <= merge(prm_reg[idx], wb_dat_i, wb_sel_i);
			if (sp_load_reg)
				prm_reg[`IDX_SP] <= pv_reg;
		end
	end

	always @(posedge clk_sys or negedge rst_s_n)
	begin
		if (!rst_s_n)
		begin
			bias_reg <= 16'h0000;
			pv_reg <= 16'h0000;
			pv_last_reg <= 16'h0000;
			y_reg <= 16'h0000;
			y_prev_reg <= 16'h0000;
			m_prev_reg <= 16'h0000;
			state_reg <= S_IDLE;
			ms_cnt_reg <= {CNT_W{1'b0}};
			smp_cnt_reg <= 16'h0000;
			primed_reg <= 1'b0;
			auto_prev_reg <= 1'b0;
			sp_load_reg <= 1'b0;
			ctrl_out <= 16'h0000;
			out_strobe <= 1'b0;
			alarm_vec <= 9'h000;
		end
		else
		begin
			sp_load_reg <= 1'b0;
			out_strobe <= 1'b0;
			if (!run)
			begin
				ms_cnt_reg <= {CNT_W{1'b0}};
				smp_cnt_reg <= 16'h0000;
				state_reg <= S_IDLE;
				primed_reg <= 1'b0;
			end
			else
			begin
				if (ms_cnt_reg == MS_LAST)
				begin
					ms_cnt_reg <= {CNT_W{1'b0}};
					smp_cnt_reg <= tick ? 16'h0000 : smp_cnt_reg + 16'h0001;
				end
				else
					ms_cnt_reg <= ms_cnt_reg + 1'b1;
				case (state_reg)
				S_IDLE:
					if (tick)
						state_reg <= S_PREP;
				S_PREP:
				begin
					// first sample seeds history to avoid a derivative kick
					pv_last_reg <= primed_reg ? pv_reg : pv_p;
					pv_reg <= pv_p;
					y_prev_reg <= primed_reg ? y_reg : pv_p;
					y_reg <= primed_reg ? y_nx[15:0] : pv_p;
					primed_reg <= 1'b1;
					state_reg <= S_CALC;
				end
				S_CALC:
				begin
					alarm_vec <= alm_nx;
					auto_prev_reg <= auto_eff;
					out_strobe <= 1'b1;
					m_prev_reg <= m_new;
					ctrl_out <= vel ? vel_fmt(m_delta, fmt) :
						to_fmt(m_new, fmt);
					if (auto_eff && xfer)
					begin
						if (!vel)
							bias_reg <= m_prev_reg;
						sp_load_reg <= !casc;
						// next sample reseeds history: no derivative kick
						if (ctrl[`CB_BUMP_II])
							primed_reg <= 1'b0;
					end
					else if (auto_eff)
						bias_reg <= bias_nx;
					state_reg <= S_IDLE;
				end
				default:
					state_reg <= S_IDLE;
				endcase
			end
			if (wr && idx == `IDX_BIAS)
				bias_reg <= merge(bias_reg, wb_dat_i, wb_sel_i);
		end
	end
endmodule
`default_nettype wire

// file: testbench/pid_loop_checker.sv
// Purpose: port timing checks of the loop engine
// Assumes: one clock, async active-low reset
// Notes: bound to every engine instance
`timescale 1ns/1ps
`default_nettype none
module pid_loop_checker #(
	parameter MS_CYCLES = 16
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic [15:0] ctrl_out,
	input wire logic out_strobe,
	input wire logic [8:0] alarm_vec
);
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	AST_ACK_LAT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("bus request not answered next cycle");
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack longer than one cycle");
	AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	AST_RDATA_HI: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
		else $error("read data upper half not zero");
	// read data must not drift while software may still sample it
	AST_RDATA_HOLD: assert property ($changed(wb_dat_o) |-> wb_ack_o)
		else $error("read data changed without ack");
	// sample period is at least MS_CYCLES, far above eight
	AST_STB_SPACE: assert property (out_strobe |=> !out_strobe [*8])
		else $error("samples too close together");
	AST_OUT_CHG: assert property ($changed(ctrl_out) |-> out_strobe)
		else $error("output moved outside a sample");
	AST_ALM_CHG: assert property ($changed(alarm_vec) |-> out_strobe)
		else $error("alarms moved outside a sample");
endmodule
bind pid_loop_calc pid_loop_checker #(.MS_CYCLES(MS_CYCLES)) i_pid_loop_checker (
	.clk_sys(clk_sys), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
	.ctrl_out(ctrl_out), .out_strobe(out_strobe), .alarm_vec(alarm_vec));
`default_nettype wire

// file: testbench/io_model.sv
// Purpose: analog input and output modules beside the loop
// Assumes: same clock as the engine
// Notes: pv lags pv_set one cycle, like a converter
`timescale 1ns/1ps
`default_nettype none
module io_model (
	input wire logic clk_sys,
	input wire logic [15:0] pv_set,
	input wire logic [15:0] ctrl_out,
	input wire logic out_strobe,
	output logic [15:0] pv_raw,
	output logic [15:0] act_pos
);
	initial pv_raw = 16'h0000;
	always @(posedge clk_sys)
	begin
		pv_raw <= pv_set;
		if (out_strobe)
			act_pos <= ctrl_out;
	end
endmodule
`default_nettype wire

// file: testbench/testbench.sv
// Purpose: self-checking bench for the loop engine
// Assumes: one-cycle bus answer, mostly 16-bit unipolar format
// Notes: each row writes one register and then the control word right after a sample
`include "pid_loop_map.vh"
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [31:0] adr = 32'h0000_0000;
	logic [31:0] dat = 32'h0000_0000;
	logic [15:0] pv_set = 16'h6000;
	logic [15:0] csp = 16'h7800;
	logic [31:0] rd;
	logic [15:0] r;
	logic [24:0] expq[$];
	int err_total = 0;
	int checks = 0;
	int cycles = 0;
	wire [31:0] dat_o;
	wire ack;
	wire strobe;
	wire [15:0] pv_raw;
	wire [15:0] ctrl_out;
	wire [8:0] alarm_vec;
	// ctrl, register, value, pv, alarms (ffff: no check), output
	logic [95:0] tbl[47] = '{
		96'h4001_000a_c000_6000_ffff_0000, 96'h4001_000b_9000_6000_ffff_0000,
		96'h4001_000c_4000_6000_ffff_0000, 96'h4001_000d_2000_6000_ffff_0000,
		96'h4001_0007_1234_d000_0003_1234,
		96'h4001_0007_1234_a000_0002_1234,
		96'h4001_0007_1234_8c00_0002_1234,
		96'h4001_0007_1234_8000_0000_1234,
		96'h4001_0007_1234_3000_0004_1234,
		96'h4001_0007_1234_1000_000c_1234,
		96'h4001_000a_0000_7000_ffff_0000, 96'h4001_000b_0000_7000_ffff_0000,
		96'h4001_000c_0000_7000_ffff_0000, 96'h4001_000d_0000_7000_ffff_0000,
		96'h4001_0011_0000_7000_ffff_0000, 96'h4001_0010_0100_7000_ffff_0000,
		96'h4001_0007_1234_6000_0100_1234,
		96'h4001_0007_1234_6000_0000_1234,
		96'h4001_0010_0000_7000_ffff_0000,
		96'h4001_0007_1234_7000_0000_1234,
		96'h4203_0010_0000_7000_0000_1234,
		96'h4203_0006_8000_7000_0000_2234,
		96'h4203_000e_0800_7000_0020_2234,
		96'h4213_000e_0000_7000_0000_0234,
		96'h4203_0001_0200_7000_0000_3234,
		96'h4203_0006_f000_7000_0000_ffff,
		96'h4213_0006_f000_7000_0000_0000,
		96'h4203_0001_0000_7000_0000_1234,
		96'h4203_0001_0100_7000_0000_9234,
		96'h4283_0006_7400_7000_0000_1234,
		96'h4283_0006_7c00_7000_0000_1e34,
		96'h4207_0006_8000_7000_0000_1a34,
		96'h420b_0006_8000_7000_ffff_0000,
		96'h420b_0006_9000_7000_0000_0800,
		96'h420b_0006_9000_7000_0000_0000,
		96'h4223_0006_8000_4000_0000_1234,
		96'h4243_0006_c000_4000_0000_5234,
		96'h42c3_0006_4c00_4000_0000_1234,
		96'h4203_0002_0002_4000_0000_2434,
		96'h4203_0002_270f_4000_0000_2434,
		96'h4203_0003_0001_4800_0000_1434,
		96'h4303_0005_0001_5800_0000_0434,
		96'h4303_0003_0000_6000_0000_0434,
		96'h0203_0006_8000_0400_0000_0583,
		96'h4001_0007_2000_4000_0000_2000,
		96'h4403_0003_0001_4000_0000_2000,
		96'h4403_0003_0001_5000_0000_1000};
	initial forever #20 clk_sys = ~clk_sys;
	io_model i_io_model (.clk_sys(clk_sys), .pv_set(pv_set),
		.ctrl_out(ctrl_out), .out_strobe(strobe), .pv_raw(pv_raw),
		.act_pos());
	pid_loop_calc #(.MS_CYCLES(16)) i_pid_loop_calc (.clk_sys(clk_sys),
		.rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .pv_raw(pv_raw), .cascade_sp(csp),
		.ctrl_out(ctrl_out), .out_strobe(strobe), .alarm_vec(alarm_vec));
	task automatic report_and_stop;
		$display("checks %0d errors %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		checks++;
		if (seen !== want)
		begin
			err_total++;
			$display("mismatch at %0t: saw %h want %h", $time, seen, want);
		end
	endtask
	task automatic wb(input logic w, input logic [4:0] i, input logic [15:0] d);
		@(posedge clk_sys);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= {25'h000_0000, i, 2'b00};
		dat <= {16'h0000, d};
		@(posedge clk_sys);
		while (ack !== 1'b1)
			@(posedge clk_sys);
		rd = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic wait_strobe;
		@(posedge clk_sys);
		while (strobe !== 1'b1)
			@(posedge clk_sys);
	endtask
	// two writes end well before the next tick, so they land in one sample
	task automatic step(input logic [95:0] e);
		pv_set <= e[47:32];
		wb(1'b1, e[68:64], e[63:48]);
		wb(1'b1, `IDX_CTRL, e[95:80]);
		if (e[31:16] != 16'hffff)
			expq.push_back({e[24:16], e[15:0]});
		wait_strobe;
	endtask
	always @(posedge clk_sys)
		if (strobe === 1'b1 && expq.size() > 0)
			chk({7'h00, alarm_vec, ctrl_out}, {7'h00, expq.pop_front()});
	always @(posedge clk_sys)
	begin
		cycles <= cycles + 1;
		if (cycles == 3000)
		begin
			err_total++;
			report_and_stop;
		end
	end
	initial
	begin
		void'($urandom(16827));
		repeat (2) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk_sys);
		wb(1'b0, `IDX_GAIN, 16'h0000);
		chk(rd, 32'h0000_0000);
		wb(1'b0, 5'h1f, 16'h0000);
		chk(rd, 32'h0000_0000);
		wb(1'b1, `IDX_SAMPLE, 16'h0001);
		wb(1'b1, `IDX_RESET, `TI_OFF);
		wb(1'b1, `IDX_DBAND, 16'h0800);
		wb(1'b1, `IDX_HYST, 16'h0800);
		wb(1'b1, `IDX_GAIN, 16'h0100);
		repeat (2)
		begin
			r = $urandom;
			step({16'h4001, 16'h0007, r, 16'h6000, 16'h0000, r});
		end
		for (int i = 0; i < 47; i++)
		begin
			if (i == 21)
			begin
				wb(1'b0, `IDX_BIAS, 16'h0000);
				chk(rd, 32'h0000_1234);
				wb(1'b0, `IDX_SP, 16'h0000);
				chk(rd, 32'h0000_7000);
				wait_strobe;
			end
			step(tbl[i]);
		end
		// let the watcher take the last note before closing
		@(posedge clk_sys);
		chk(expq.size(), 0);
		report_and_stop;
	end
endmodule
`default_nettype wire
